// [hdl/qdr_readback.sv]
`timescale 1ns/1ps
`default_nettype none
module qdr_readback
   import qdr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic pin_addr_bit_hi,
   input wire logic pin_addr_bit_lo,
   input wire logic [QDR_NUM_CHAN-1:0][QDR_WORD_W-1:0] chan_word,
   input wire qdr_pdmode_t [QDR_NUM_CHAN-1:0] chan_pdmode,
   output logic power_down_flag,
   output logic [1:0] chan_sel,
   output logic [1:0] load_mode,
   output logic ext_addr_bit_hi,
   output logic ext_addr_bit_lo,
   output logic read_active
);
   qdr_line_if scl_line ();
   qdr_line_if sda_line ();

   assign scl_line.raw = scl_i;
   assign sda_line.raw = sda_i;

   qdr_pin_filter u_scl_filter (.sys_clk(sys_clk), .rst(rst), .line(scl_line.filt));
   qdr_pin_filter u_sda_filter (.sys_clk(sys_clk), .rst(rst), .line(sda_line.filt));

   qdr_state_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic ack_q, ack_d;
   logic [7:0] sr_q, sr_d;
   logic [7:0] tx_q, tx_d;
   logic [1:0] bidx_q, bidx_d;
   logic nack_q, nack_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic drive_q;
   logic scl_prev_q;
   logic sda_prev_q;

   wire scl = scl_line.level;
   wire sda = sda_line.level;
   wire scl_rise = scl & ~scl_prev_q;
   wire scl_fall = ~scl & scl_prev_q;
   wire start_cond = scl & scl_prev_q & sda_prev_q & ~sda;
   wire stop_cond = scl & scl_prev_q & ~sda_prev_q & sda;

   wire [7:0] addr_w = {QDR_ADDR_FIXED, pin_addr_bit_hi, pin_addr_bit_lo, QDR_DIR_WRITE};
   wire [7:0] addr_r = {QDR_ADDR_FIXED, pin_addr_bit_hi, pin_addr_bit_lo, QDR_DIR_READ};

   // control fields
   assign power_down_flag = ctrl_q[QDR_CTRL_PD_BIT];
   assign chan_sel = ctrl_q[QDR_CTRL_SEL_LSB +: 2];
   assign load_mode = ctrl_q[QDR_CTRL_LOAD_LSB +: 2];
   assign ext_addr_bit_lo = ctrl_q[QDR_CTRL_EXT_LSB];
   assign ext_addr_bit_hi = ctrl_q[QDR_CTRL_EXT_LSB+1];

   // byte source selection
   wire [QDR_WORD_W-1:0] sel_word = chan_word[chan_sel];
   wire qdr_pdmode_t sel_pd = chan_pdmode[chan_sel];
   wire [7:0] status_byte = {sel_pd, QDR_STATUS_FILL};
   wire [7:0] hi_byte = sel_word[15:8];
   wire [7:0] lo_byte = sel_word[7:0];
   wire [1:0] cur_kind = power_down_flag ? bidx_q : 2'(bidx_q + 2'h1);
   wire qdr_byte_t first_kind = power_down_flag ? QDR_BYTE_STATUS : QDR_BYTE_HI;
   wire [1:0] load_kind = (st_q == QDR_ST_RADDR) ? first_kind : 2'(cur_kind + 2'h1);
   wire last_byte = (cur_kind == QDR_BYTE_LO);
   wire [7:0] load_byte = (load_kind == QDR_BYTE_STATUS) ? status_byte :
                          (load_kind == QDR_BYTE_HI) ? hi_byte : lo_byte;
   wire byte_ok = (st_q == QDR_ST_CTRL) ||
                  (st_q == QDR_ST_WADDR && sr_q == addr_w) ||
                  (st_q == QDR_ST_RADDR && sr_q == addr_r);
   wire receiving = (st_q == QDR_ST_WADDR) || (st_q == QDR_ST_CTRL) || (st_q == QDR_ST_RADDR);
   // open drain: only ever pull low, and only in our own slots
   wire drive_d = ack_q | ((st_q == QDR_ST_SEND) & ~tx_q[7]);

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      ack_d = ack_q;
      sr_d = sr_q;
      tx_d = tx_q;
      bidx_d = bidx_q;
      nack_d = nack_q;
      ctrl_d = ctrl_q;
      if (stop_cond) begin
         st_d = QDR_ST_IDLE;
         cnt_d = '0;
         ack_d = 1'b0;
      end else if (start_cond) begin
         // a repeated start right after the control byte opens the read,
         // any other start restarts addressing
         st_d = (st_q == QDR_ST_WAIT_RS) ? QDR_ST_RADDR : QDR_ST_WADDR;
         cnt_d = '0;
         ack_d = 1'b0;
      end else if (receiving) begin
         if (scl_rise && cnt_q < QDR_BITS_PER_BYTE) begin
            sr_d = {sr_q[6:0], sda};
            cnt_d = 4'(cnt_q + 4'h1);
         end else if (scl_fall && cnt_q == QDR_BITS_PER_BYTE && !ack_q) begin
            if (byte_ok) begin
               ack_d = 1'b1;
               if (st_q == QDR_ST_CTRL) begin
                  ctrl_d = sr_q;
               end
            end else begin
               st_d = QDR_ST_IDLE;
            end
         end else if (scl_fall && ack_q) begin
            ack_d = 1'b0;
            cnt_d = '0;
            unique case (st_q)
               QDR_ST_WADDR: st_d = QDR_ST_CTRL;
               QDR_ST_CTRL: st_d = QDR_ST_WAIT_RS;
               QDR_ST_RADDR: begin
                  st_d = QDR_ST_SEND;
                  tx_d = load_byte;
                  bidx_d = '0;
               end
               default: st_d = st_q;
            endcase
         end
      end else if (st_q == QDR_ST_SEND) begin
         if (scl_fall) begin
            if (cnt_q == QDR_LAST_BIT) begin
               st_d = QDR_ST_MACK;
               cnt_d = '0;
            end else begin
               tx_d = {tx_q[6:0], 1'b1};
               cnt_d = 4'(cnt_q + 4'h1);
            end
         end
      end else if (st_q == QDR_ST_MACK) begin
         if (scl_rise) begin
            nack_d = sda;
         end else if (scl_fall) begin
            // an ack on the final byte is not honoured: nothing is left to send
            if (!nack_q && !last_byte) begin
               bidx_d = 2'(bidx_q + 2'h1);
               tx_d = load_byte;
               st_d = QDR_ST_SEND;
            end else begin
               st_d = QDR_ST_DONE;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= QDR_ST_IDLE;
         cnt_q <= '0;
         ack_q <= 1'b0;
         sr_q <= '0;
         tx_q <= '0;
         bidx_q <= '0;
         nack_q <= 1'b0;
         ctrl_q <= QDR_CTRL_RESET;
         drive_q <= 1'b0;
         scl_prev_q <= QDR_LINE_IDLE;
         sda_prev_q <= QDR_LINE_IDLE;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         ack_q <= ack_d;
         sr_q <= sr_d;
         tx_q <= tx_d;
         bidx_q <= bidx_d;
         nack_q <= nack_d;
         ctrl_q <= ctrl_d;
         drive_q <= drive_d;
         scl_prev_q <= scl;
         sda_prev_q <= sda;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe = drive_q;
   assign read_active = (st_q == QDR_ST_SEND) || (st_q == QDR_ST_MACK);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence ack_open_s;
      scl_fall && cnt_q == QDR_BITS_PER_BYTE && !ack_q;
   endsequence

   addr_reject_a: assert property (
      (st_q == QDR_ST_WADDR) and ack_open_s and (sr_q != addr_w) |=> st_q == QDR_ST_IDLE)
      else $error("bad write address not rejected");
   ctrl_latch_a: assert property (
      (st_q == QDR_ST_CTRL) and ack_open_s |=> ctrl_q == $past(sr_q) ##1 drive_q)
      else $error("control byte not latched or acknowledged");
   read_ack_a: assert property (
      (st_q == QDR_ST_RADDR) and ack_open_s and (sr_q == addr_r) |=> ack_q ##1 drive_q)
      else $error("read address not acknowledged");
   first_byte_a: assert property (
      st_q == QDR_ST_RADDR && ack_q && scl_fall |=>
      tx_q == (power_down_flag ? status_byte : hi_byte))
      else $error("wrong first readback byte");
   status_fill_a: assert property (
      st_q == QDR_ST_SEND && cnt_q == '0 && cur_kind == QDR_BYTE_STATUS |->
      tx_q[5:0] == QDR_STATUS_FILL && tx_q[7:6] == sel_pd)
      else $error("status byte layout wrong");
   low_byte_a: assert property (
      st_q == QDR_ST_SEND && cnt_q == '0 && cur_kind == QDR_BYTE_LO |-> tx_q == lo_byte)
      else $error("low byte not from selected channel");
   mack_release_a: assert property (
      st_q == QDR_ST_MACK && $past(st_q == QDR_ST_MACK) |-> !drive_q)
      else $error("sda driven in master ack slot");
   nack_stop_a: assert property (
      st_q == QDR_ST_MACK && nack_q && scl_fall && !start_cond && !stop_cond
      |=> st_q == QDR_ST_DONE ##1 !drive_q)
      else $error("bytes continued after not-acknowledge");
   read_restart_a: assert property (
      start_cond && (st_q == QDR_ST_SEND || st_q == QDR_ST_MACK || st_q == QDR_ST_DONE)
      |=> st_q == QDR_ST_WADDR)
      else $error("repeated start after read did not restart addressing");
endmodule : qdr_readback
`default_nettype wire

// [inc/qdr_pkg.sv]
`default_nettype none
package qdr_pkg;
   localparam logic [4:0] QDR_ADDR_FIXED = 5'h13;
   localparam logic QDR_DIR_WRITE = 1'h0;
   localparam logic QDR_DIR_READ = 1'h1;
   localparam logic [3:0] QDR_BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] QDR_LAST_BIT = 4'h7;
   localparam int QDR_CTRL_PD_BIT = 0;
   localparam int QDR_CTRL_SEL_LSB = 1;
   localparam int QDR_CTRL_LOAD_LSB = 4;
   localparam int QDR_CTRL_EXT_LSB = 6;
   localparam logic [7:0] QDR_CTRL_RESET = 8'h00;
   localparam logic [5:0] QDR_STATUS_FILL = 6'h3f;
   localparam logic QDR_LINE_IDLE = 1'h1;
   localparam int QDR_NUM_CHAN = 4;
   localparam int QDR_WORD_W = 16;

   typedef enum logic [1:0] {
      QDR_PD_HIZ = 2'h0,
      QDR_PD_1K_GND = 2'h1,
      QDR_PD_100K_GND = 2'h2,
      QDR_PD_HIZ_ALT = 2'h3
   } qdr_pdmode_t;

   typedef enum logic [1:0] {
      QDR_BYTE_STATUS = 2'h0,
      QDR_BYTE_HI = 2'h1,
      QDR_BYTE_LO = 2'h2
   } qdr_byte_t;

   typedef enum logic [2:0] {
      QDR_ST_IDLE = 3'h0,
      QDR_ST_WADDR = 3'h1,
      QDR_ST_CTRL = 3'h3,
      QDR_ST_WAIT_RS = 3'h2,
      QDR_ST_RADDR = 3'h6,
      QDR_ST_SEND = 3'h7,
      QDR_ST_MACK = 3'h5,
      QDR_ST_DONE = 3'h4
   } qdr_state_t;
endpackage : qdr_pkg
`default_nettype wire

// [inc/qdr_line_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface qdr_line_if;
   logic raw;
   logic level;
   modport filt (input raw, output level);
   modport sink (output raw, input level);
endinterface : qdr_line_if
`default_nettype wire

// [hdl/qdr_pin_filter.sv]
`timescale 1ns/1ps
`default_nettype none
module qdr_pin_filter
   import qdr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   qdr_line_if.filt line
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;

   // level only moves once the last two stages agree, so a bit that is
   // still settling in the first stage never reaches the decoder
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s1_q <= QDR_LINE_IDLE;
         s2_q <= QDR_LINE_IDLE;
         s3_q <= QDR_LINE_IDLE;
         level_q <= QDR_LINE_IDLE;
      end else begin
         s1_q <= line.raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end

   assign line.level = level_q;
endmodule : qdr_pin_filter
`default_nettype wire

// [verif/qdr_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
module qdr_bus_model (
   input wire logic sys_clk,
   input wire logic sda_line,
   output logic scl_q,
   output logic pull_q
);
   initial begin
      scl_q = 1'b1;
      pull_q = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : w
   // also serves as repeated start, since scl is low between bytes
   task automatic start();
      pull_q = 1'b0;
      w(8);
      scl_q = 1'b1;
      w(8);
      pull_q = 1'b1;
      w(8);
      scl_q = 1'b0;
      w(3);
   endtask : start
   task automatic stop();
      pull_q = 1'b1;
      w(8);
      scl_q = 1'b1;
      w(8);
      pull_q = 1'b0;
      w(8);
   endtask : stop
   // sda moves 3 cycles after scl falls so the device never sees a false start
   task automatic bit_io(input logic b, output logic s);
      pull_q = ~b;
      w(8);
      scl_q = 1'b1;
      w(5);
      s = sda_line;
      w(5);
      scl_q = 1'b0;
      w(3);
   endtask : bit_io
   task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q,
                       output logic s9);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(nine, s9);
   endtask : xfer
endmodule : qdr_bus_model
`default_nettype wire

// [verif/qdr_readback_test.sv]
`timescale 1ns/1ps
`default_nettype none
module qdr_readback_test
   import qdr_pkg::*;
;
   logic sys_clk, rst, pin_addr_bit_hi, pin_addr_bit_lo, scl, pull;
   logic sda_o, sda_oe, pdf, ext_hi, ext_lo, act;
   logic [1:0] sel, ldm;
   logic [QDR_NUM_CHAN-1:0][QDR_WORD_W-1:0] word;
   qdr_pdmode_t [QDR_NUM_CHAN-1:0] pdm;
   wire logic sda_line;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   // pull-up on the line; either party may only pull it low
   assign sda_line = ((sda_oe & ~sda_o) | pull) ? 1'b0 : 1'b1;
   qdr_readback dut (.sys_clk(sys_clk), .rst(rst), .scl_i(scl), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe(sda_oe), .pin_addr_bit_hi(pin_addr_bit_hi),
      .pin_addr_bit_lo(pin_addr_bit_lo), .chan_word(word), .chan_pdmode(pdm),
      .power_down_flag(pdf), .chan_sel(sel), .load_mode(ldm),
      .ext_addr_bit_hi(ext_hi), .ext_addr_bit_lo(ext_lo), .read_active(act));
   qdr_bus_model bus (.sys_clk(sys_clk), .sda_line(sda_line), .scl_q(scl), .pull_q(pull));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic give_verdict();
      if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   function automatic logic [7:0] exp_byte(input logic [7:0] ctrl, input int k);
      logic [15:0] wd;
      wd = word[ctrl[2:1]];
      if (ctrl[0] && k == 0) return {pdm[ctrl[2:1]], 6'h3f};
      return (k - int'(ctrl[0]) == 0) ? wd[15:8] : wd[7:0];
   endfunction : exp_byte
   task automatic shuffle();
      for (int c = 0; c < QDR_NUM_CHAN; c++) begin
         word[c] = 16'($urandom);
         pdm[c] = qdr_pdmode_t'(2'($urandom));
      end
      {pin_addr_bit_hi, pin_addr_bit_lo} = 2'($urandom);
   endtask : shuffle
   // xtra: master acks the low byte and clocks one more, which must read as idle
   task automatic txn(input logic [7:0] ctrl, input logic [4:0] fx, input logic rmis,
                      input logic xtra, input logic fin);
      logic [7:0] q;
      logic s9;
      int n;
      n = 2 + int'(ctrl[0]);
      bus.start();
      bus.xfer({fx, pin_addr_bit_hi, pin_addr_bit_lo, 1'b0}, 1'b1, q, s9);
      check("waddr_ack", {7'h0, fx != 5'h13}, {7'h0, s9});
      if (s9) begin
         bus.stop();
         return;
      end
      bus.xfer(ctrl, 1'b1, q, s9);
      check("ctrl_ack", 8'h00, {7'h0, s9});
      check("ctrl_fields", {1'b0, ctrl[7:4], ctrl[2:0]},
            {1'b0, ext_hi, ext_lo, ldm, sel, pdf});
      bus.start();
      bus.xfer({5'h13, pin_addr_bit_hi, pin_addr_bit_lo ^ rmis, 1'b1}, 1'b1, q, s9);
      check("raddr_ack", {7'h0, rmis}, {7'h0, s9});
      if (s9) begin
         bus.stop();
         return;
      end
      for (int k = 0; k < n + int'(xtra); k++) begin
         bus.xfer(8'hff, k >= n - 1 + int'(xtra), q, s9);
         check("rd_byte", (k < n) ? exp_byte(ctrl, k) : 8'hff, q);
         // the ack slot state still stands here, half a cycle before the filtered fall lands
         check("rd_active", {7'h0, k < n}, {7'h0, act});
      end
      bus.w(8);
      check("released", 8'h04, {5'h0, s9, sda_oe, act});
      if (fin) bus.stop();
   endtask : txn
   initial begin
      rst = 1'b1;
      void'($urandom(32'h2d14));
      shuffle();
      repeat (10) @(negedge sys_clk);
      check("reset_vals", 8'h00, {ext_hi, ext_lo, ldm, sel, pdf, sda_oe});
      rst = 1'b0;
      bus.w(8);
      for (int i = 0; i < 20; i++) begin
         shuffle();
         // first two pass all-zero and all-one control bytes; then every channel and flag
         txn((i < 2) ? {8{i[0]}} : {5'($urandom), i[1:0], i[2]},
             (i == 5) ? 5'h12 : 5'h13, i == 7, i[3], i[0]);
      end
      give_verdict();
   end
endmodule : qdr_readback_test
`default_nettype wire
